//--- hdl/afs_consts.svh
`ifndef AFS_CONSTS_SVH
`define AFS_CONSTS_SVH

// Special register numbers.
`define AFS_SPR_STEP     8'h83
`define AFS_SPR_ALU      8'h84
`define AFS_SPR_ENV      8'ha0
`define AFS_SPR_FST      8'ha2

// ALU status field positions.
`define AFS_ALU_DF       11
`define AFS_ALU_V        10
`define AFS_ALU_N        9
`define AFS_ALU_Z        8
`define AFS_ALU_C        7

// Floating-point status and environment layout.
`define AFS_EXC_W        6
`define AFS_FST_TRAP_LO  8
`define AFS_FST_TRAP_HI  13
`define AFS_FST_STK_LO   0
`define AFS_FST_STK_HI   5
`define AFS_ENV_MSK_HI   5

// Exception index inside each six-bit group.
`define AFS_EXC_DZ       5
`define AFS_EXC_RO       1

// Reset values.
`define AFS_RST_EXC      6'h00
`define AFS_RST_WORD     32'h00000000
`define AFS_RST_DF       1'b1

`endif

//--- hdl/afs_pkg.sv
package afs_pkg;

    // Instruction class, one-hot.
    typedef enum logic [3:0] {
        AFS_OP_ARITH = 4'h1,
        AFS_OP_LOGIC = 4'h2,
        AFS_OP_MULST = 4'h4,
        AFS_OP_DIVST = 4'h8
    } afs_op_t;

    // Add flavour for arithmetic class.
    typedef enum logic [1:0] {
        AFS_ADD  = 2'h0,
        AFS_ADDC = 2'h1,
        AFS_SUB  = 2'h2,
        AFS_SUBC = 2'h3
    } afs_add_t;

    // Logical function.
    typedef enum logic [1:0] {
        AFS_AND  = 2'h0,
        AFS_OR   = 2'h1,
        AFS_XOR  = 2'h2,
        AFS_ANDN = 2'h3
    } afs_logic_t;

endpackage

//--- hdl/afs_adder.sv
`timescale 1ns/100ps

module afs_adder #(
    parameter int WIDTH = 32
) (
    // Operands.
    input  wire logic [WIDTH-1:0] a,
    input  wire logic [WIDTH-1:0] b,
    input  wire logic             cin,
    // Result.
    output logic      [WIDTH-1:0] sum,
    output logic                  cout,
    output logic                  carryMsb
);

    initial begin
        if (WIDTH < 2) begin
            $error("afs_adder needs WIDTH of at least 2");
        end
    end

    logic [WIDTH-1:0] lowSum;

    // The top bit is added apart so that the carry into it is visible.
    always_comb begin
        lowSum = WIDTH'({1'b0, a[WIDTH-2:0]} + {1'b0, b[WIDTH-2:0]} + {{(WIDTH-1){1'b0}}, cin});
        carryMsb = lowSum[WIDTH-1];
        sum = {a[WIDTH-1] ^ b[WIDTH-1] ^ carryMsb, lowSum[WIDTH-2:0]};
        cout = (a[WIDTH-1] & b[WIDTH-1]) | (carryMsb & (a[WIDTH-1] ^ b[WIDTH-1]));
    end

endmodule

//--- hdl/afs_core.sv
`timescale 1ns/100ps
`include "afs_consts.svh"

// Summary of operation
// RULE_01: Arithmetic, multiply-step and divide-step ops update V, N, Z, C from their add.
// RULE_02: Subtract adds the one's or two's complement of an operand.
// RULE_03: V is carry into MSB xor carry out, also for unsigned ops.
// RULE_04: N is the MSB of the unshifted add result.
// RULE_05: Z is set when the word written back is zero, shifted if stepped.
// RULE_06: C takes the carry out of the add.
// RULE_07: Logical ops update only N and Z; V and C hold.
// RULE_08: Logical N is result MSB; Z set when result word is zero.
// RULE_09: An exception sets its sticky bit whenever its mask bit is one.
// RULE_10: On a trap, every trap bit is loaded with its condition, masks ignored.
// RULE_11: Sticky bits clear only by software write of the status register.
// RULE_12: Only masked sticky bits update, at the end of the operation.
// RULE_13: Operations without an unmasked trap leave trap bits unchanged.
// RULE_14: Trap bits sit at 13..8: divzero, inexact, underflow, overflow, reserved, invalid.
// RULE_15: Sticky bits sit at 5..0 in the same order; 7..6 reserved.
// RULE_16: Divide by zero needs zero divisor and non-zero finite dividend.
// RULE_17: Reserved sticky covers input or result; reserved trap only a reserved result.
// RULE_18: Multiply and divide steps use the step operand with both sources.
// RULE_19: Divide steps keep low dividend bits in step operand, ending with quotient.
// RULE_20: Multiply steps keep the multiplier there, ending with low product bits.
// RULE_21: Full divide starts with high dividend there, ends with remainder.
// RULE_22: Mask bits sit at 5..0; one suppresses the trap, zero allows it.
// RULE_23: ALU status holds V at 10, N at 9, Z at 8, C at 7.
// RULE_24: Reserved status bits read zero and ignore writes.
module afs_core
    import afs_pkg::*;
#(
    parameter int WIDTH = 32
) (
    // Clock and reset.
    input  wire logic                 clock,
    input  wire logic                 rstn,
    input  wire logic                 clkEn,
    // Integer operation.
    input  wire logic                 opValid,
    input  wire afs_pkg::afs_op_t     opClass,
    input  wire afs_pkg::afs_add_t    addMode,
    input  wire afs_pkg::afs_logic_t  logicFn,
    input  wire logic [WIDTH-1:0]     srcA,
    input  wire logic [WIDTH-1:0]     srcB,
    output logic      [WIDTH-1:0]     resultData,
    output logic                      resultValid,
    // Flags.
    output logic                      flagV,
    output logic                      flagN,
    output logic                      flagZ,
    output logic                      flagC,
    output logic                      divFlag,
    // Floating-point exception report.
    input  wire logic                 fpValid,
    input  wire logic [5:0]           fpCond,
    input  wire logic                 fpDivide,
    input  wire logic                 fpDividendFinNz,
    input  wire logic                 fpResvInput,
    output logic                      fpTrap,
    // Special register access.
    input  wire logic [7:0]           sprAddr,
    input  wire logic                 sprWrite,
    input  wire logic                 sprRead,
    input  wire logic [WIDTH-1:0]     sprWdata,
    output logic      [WIDTH-1:0]     sprRdata
);

    import afs_pkg::*;

    initial begin
        if (WIDTH != 32) begin
            $error("afs_core register layout serves WIDTH 32 only");
        end
    end

    function automatic logic isZero(input logic [WIDTH-1:0] w);
        isZero = (w == '0);
    endfunction

    logic [WIDTH-1:0] stepOperand;
    logic [5:0]       trapBits;
    logic [5:0]       stickyBits;
    logic [5:0]       envMask;

    logic [WIDTH-1:0] addA;
    logic [WIDTH-1:0] addB;
    logic             addCin;
    logic [WIDTH-1:0] addSum;
    logic             addCout;
    logic             addCmsb;
    logic             addOvf;
    logic [WIDTH-1:0] next_result;
    logic [WIDTH-1:0] next_step;
    logic [WIDTH-1:0] logicRes;
    logic [5:0]       cond;
    logic [5:0]       stickyCond;
    logic [5:0]       stickySet;
    logic             isArith;
    logic             isStep;
    logic             aluWr;

    assign isArith = opValid && (opClass == AFS_OP_ARITH || opClass == AFS_OP_MULST
                                 || opClass == AFS_OP_DIVST);
    assign isStep = opClass == AFS_OP_MULST || opClass == AFS_OP_DIVST;
    assign aluWr = sprWrite && sprAddr == `AFS_SPR_ALU;

    // Operand selection for the single adder shared by all add-type ops.
    always_comb begin
        addA = srcB;
        addB = srcA;
        addCin = 1'b0;
        case (opClass)
            AFS_OP_ARITH: begin
                addA = srcA;
                case (addMode)
                    AFS_ADD: begin
                        addB = srcB;
                        addCin = 1'b0;
                    end
                    AFS_ADDC: begin
                        addB = srcB;
                        addCin = flagC;
                    end
                    AFS_SUB: begin
                        addB = ~srcB; // RULE_02
                        addCin = 1'b1;
                    end
                    AFS_SUBC: begin
                        addB = ~srcB; // RULE_02
                        addCin = flagC;
                    end
                    default: begin
                        addB = srcB;
                    end
                endcase
            end
            AFS_OP_MULST: begin
                addA = srcB;
                addB = stepOperand[0] ? srcA : '0; // RULE_18 RULE_20
            end
            AFS_OP_DIVST: begin
                // Partial remainder shifts left before the add, pulling a dividend bit from the step operand.
                addA = {srcB[WIDTH-2:0], stepOperand[WIDTH-1]}; // RULE_18 RULE_19 RULE_21
                addB = divFlag ? ~srcA : srcA; // RULE_02
                addCin = divFlag;
            end
            default: begin
                addA = srcB;
            end
        endcase
    end

    afs_adder #(
        .WIDTH    (WIDTH)
    ) u_adder (
        .a        (addA),
        .b        (addB),
        .cin      (addCin),
        .sum      (addSum),
        .cout     (addCout),
        .carryMsb (addCmsb)
    );

    assign addOvf = addCout ^ addCmsb; // RULE_03

    always_comb begin
        case (logicFn)
            AFS_AND:  logicRes = srcA & srcB;
            AFS_OR:   logicRes = srcA | srcB;
            AFS_XOR:  logicRes = srcA ^ srcB;
            AFS_ANDN: logicRes = srcA & ~srcB;
            default:  logicRes = srcA & srcB;
        endcase
    end

    // Written value and next step operand.
    always_comb begin
        next_result = addSum;
        next_step = stepOperand;
        case (opClass)
            AFS_OP_LOGIC: begin
                next_result = logicRes;
            end
            AFS_OP_MULST: begin
                // Shift right with the true sign so signed products stay correct.
                next_result = {addSum[WIDTH-1] ^ addOvf, addSum[WIDTH-1:1]};
                next_step = {addSum[0], stepOperand[WIDTH-1:1]}; // RULE_20
            end
            AFS_OP_DIVST: begin
                next_step = {stepOperand[WIDTH-2:0], addCout}; // RULE_19 RULE_21
            end
            default: begin
                next_result = addSum;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            resultData <= `AFS_RST_WORD;
            resultValid <= 1'b0;
        end else if (clkEn) begin
            resultValid <= opValid;
            if (opValid) begin
                resultData <= next_result;
            end
        end
    end

    // Hardware updates win over a same-cycle status register write.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            flagV <= 1'b0;
            flagN <= 1'b0;
            flagZ <= 1'b0;
            flagC <= 1'b0;
        end else if (clkEn) begin
            if (isArith) begin
                flagV <= addOvf; // RULE_01 RULE_03
                flagN <= addSum[WIDTH-1]; // RULE_04
                flagZ <= isZero(next_result); // RULE_05
                flagC <= addCout; // RULE_06
            end else if (opValid && opClass == AFS_OP_LOGIC) begin
                flagN <= logicRes[WIDTH-1]; // RULE_07 RULE_08
                flagZ <= isZero(logicRes); // RULE_08
            end else if (aluWr) begin
                flagV <= sprWdata[`AFS_ALU_V]; // RULE_23
                flagN <= sprWdata[`AFS_ALU_N];
                flagZ <= sprWdata[`AFS_ALU_Z];
                flagC <= sprWdata[`AFS_ALU_C];
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            divFlag <= `AFS_RST_DF;
        end else if (clkEn) begin
            if (opValid && opClass == AFS_OP_DIVST) begin
                divFlag <= addCout;
            end else if (aluWr) begin
                divFlag <= sprWdata[`AFS_ALU_DF];
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            stepOperand <= `AFS_RST_WORD;
        end else if (clkEn) begin
            if (opValid && isStep) begin
                stepOperand <= next_step; // RULE_18
            end else if (sprWrite && sprAddr == `AFS_SPR_STEP) begin
                stepOperand <= sprWdata;
            end
        end
    end

    // Floating-point exceptions.
    always_comb begin
        cond = fpCond;
        cond[`AFS_EXC_DZ] = fpCond[`AFS_EXC_DZ] && fpDivide && fpDividendFinNz; // RULE_16
        stickyCond = cond;
        stickyCond[`AFS_EXC_RO] = fpCond[`AFS_EXC_RO] || fpResvInput; // RULE_17
    end

    // A reserved input also traps when unmasked, though only a reserved result shows in the trap bit.
    assign fpTrap = fpValid && |(stickyCond & ~envMask); // RULE_22
    assign stickySet = (fpValid && clkEn) ? (stickyCond & envMask) : `AFS_RST_EXC; // RULE_09 RULE_12

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            envMask <= `AFS_RST_EXC;
        end else if (clkEn && sprWrite && sprAddr == `AFS_SPR_ENV) begin
            envMask <= sprWdata[`AFS_ENV_MSK_HI:0]; // RULE_22
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            stickyBits <= `AFS_RST_EXC;
        end else if (clkEn) begin
            if (sprWrite && sprAddr == `AFS_SPR_FST) begin
                stickyBits <= sprWdata[`AFS_FST_STK_HI:`AFS_FST_STK_LO] | stickySet; // RULE_11
            end else begin
                stickyBits <= stickyBits | stickySet; // RULE_11 RULE_12
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            trapBits <= `AFS_RST_EXC;
        end else if (clkEn) begin
            if (fpTrap) begin
                trapBits <= cond; // RULE_10 RULE_13 RULE_17
            end else if (sprWrite && sprAddr == `AFS_SPR_FST) begin
                trapBits <= sprWdata[`AFS_FST_TRAP_HI:`AFS_FST_TRAP_LO];
            end
        end
    end

    // Read data is registered, one cycle after the read strobe.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sprRdata <= `AFS_RST_WORD;
        end else if (clkEn && sprRead) begin
            sprRdata <= `AFS_RST_WORD;
            case (sprAddr)
                `AFS_SPR_STEP: sprRdata <= stepOperand;
                `AFS_SPR_ALU: begin
                    sprRdata[`AFS_ALU_DF] <= divFlag;
                    sprRdata[`AFS_ALU_V] <= flagV; // RULE_23
                    sprRdata[`AFS_ALU_N] <= flagN;
                    sprRdata[`AFS_ALU_Z] <= flagZ;
                    sprRdata[`AFS_ALU_C] <= flagC;
                end
                `AFS_SPR_ENV: sprRdata[`AFS_ENV_MSK_HI:0] <= envMask;
                `AFS_SPR_FST: begin
                    sprRdata[`AFS_FST_TRAP_HI:`AFS_FST_TRAP_LO] <= trapBits; // RULE_14 RULE_24
                    sprRdata[`AFS_FST_STK_HI:`AFS_FST_STK_LO] <= stickyBits; // RULE_15
                end
                default: sprRdata <= `AFS_RST_WORD;
            endcase
        end
    end

    carry_add_a: assert property (@(posedge clock) disable iff (!rstn) // RULE_06
        clkEn && opValid && opClass == AFS_OP_ARITH && addMode == AFS_ADD |=>
            flagC == 1'((33'($past(srcA)) + 33'($past(srcB))) >> WIDTH))
        else $error("carry flag differs from add carry");

    ovf_sub_a: assert property (@(posedge clock) disable iff (!rstn) // RULE_03
        clkEn && opValid && opClass == AFS_OP_ARITH && addMode == AFS_SUB |=>
            flagV == ($past(srcA[WIDTH-1]) != $past(srcB[WIDTH-1])
                      && $past(srcA[WIDTH-1]) != resultData[WIDTH-1]))
        else $error("overflow flag wrong after subtract");

    neg_unshift_a: assert property (@(posedge clock) disable iff (!rstn) // RULE_04
        clkEn && isArith |=>
            flagN == (($past(opClass) == AFS_OP_MULST) ? resultData[WIDTH-2] : resultData[WIDTH-1]))
        else $error("negative flag not from unshifted add");

    zero_written_a: assert property (@(posedge clock) disable iff (!rstn) // RULE_05
        clkEn && opValid |=> resultValid && flagZ == (resultData == '0))
        else $error("zero flag disagrees with written word");

    logic_keep_a: assert property (@(posedge clock) disable iff (!rstn) // RULE_07
        clkEn && opValid && opClass == AFS_OP_LOGIC |=> $stable(flagV) && $stable(flagC))
        else $error("logical op changed V or C");

    mul_shift_a: assert property (@(posedge clock) disable iff (!rstn) // RULE_20
        clkEn && opValid && opClass == AFS_OP_MULST |=>
            stepOperand[WIDTH-2:0] == $past(stepOperand[WIDTH-1:1]))
        else $error("multiply step did not shift step operand");

    sticky_set_a: assert property (@(posedge clock) disable iff (!rstn) // RULE_09
        clkEn && fpValid && |(cond & envMask) |=> (($past(cond) & $past(envMask)) & ~stickyBits) == '0)
        else $error("masked exception did not set sticky");

    sticky_hold_a: assert property (@(posedge clock) disable iff (!rstn) // RULE_11
        !(sprWrite && sprAddr == `AFS_SPR_FST) |=> (stickyBits & $past(stickyBits)) == $past(stickyBits))
        else $error("sticky bit cleared by hardware");

    trap_keep_a: assert property (@(posedge clock) disable iff (!rstn) // RULE_13
        !fpTrap && !(sprWrite && sprAddr == `AFS_SPR_FST) |=> $stable(trapBits))
        else $error("trap bits changed without a trap");

    dz_qual_a: assert property (@(posedge clock) disable iff (!rstn) // RULE_16
        clkEn && fpTrap && !fpDivide |=> !trapBits[`AFS_EXC_DZ])
        else $error("divide by zero trap without a divide");

    fst_resv_a: assert property (@(posedge clock) disable iff (!rstn) // RULE_24
        clkEn && sprRead && sprAddr == `AFS_SPR_FST |=>
            sprRdata[WIDTH-1:`AFS_FST_TRAP_HI+1] == '0
            && sprRdata[`AFS_FST_TRAP_LO-1:`AFS_FST_STK_HI+1] == 2'h0)
        else $error("reserved status bits read non-zero");

endmodule

//--- testbench/afs_pipe_model.sv
`timescale 1ns/100ps

// Stands in for the decode and execute pipeline. doOp, fpReport, sprWr and sprRd are entered just after a rising
// edge and return just after the edge that took their request. A request stands until the next
// call replaces it, so that no strobe is lowered and raised in one time step; callers
// therefore issue their calls back to back.
module afs_pipe_model (
    // Observed outputs.
    input  wire logic                clock,
    input  wire logic                fpTrap,
    input  wire logic [31:0]         sprRdata,
    // Integer operation.
    output logic                     clkEn,
    output logic                     opValid,
    output afs_pkg::afs_op_t         opClass,
    output afs_pkg::afs_add_t        addMode,
    output afs_pkg::afs_logic_t      logicFn,
    output logic [31:0]              srcA,
    output logic [31:0]              srcB,
    // Floating-point report.
    output logic                     fpValid,
    output logic [5:0]               fpCond,
    output logic                     fpDivide,
    output logic                     fpDividendFinNz,
    output logic                     fpResvInput,
    // Special register access.
    output logic [7:0]               sprAddr,
    output logic                     sprWrite,
    output logic                     sprRead,
    output logic [31:0]              sprWdata
);
    import afs_pkg::*;

    initial begin
        clkEn = 1'b1;
        opValid = 1'b0;
        opClass = AFS_OP_ARITH;
        addMode = AFS_ADD;
        logicFn = AFS_AND;
        srcA = 32'h0;
        srcB = 32'h0;
        fpValid = 1'b0;
        fpCond = 6'h00;
        fpDivide = 1'b0;
        fpDividendFinNz = 1'b0;
        fpResvInput = 1'b0;
        sprAddr = 8'h00;
        sprWrite = 1'b0;
        sprRead = 1'b0;
        sprWdata = 32'h0;
    end

    task automatic setEnable(input logic en);
        clkEn = en;
    endtask

    // Each strobe gets exactly one assignment per request.
    task automatic strobe(input logic ov, input logic fv, input logic wr, input logic rd);
        opValid = ov;
        fpValid = fv;
        sprWrite = wr;
        sprRead = rd;
    endtask

    task automatic doOp(input afs_op_t c, input afs_add_t m, input afs_logic_t f,
                        input logic [31:0] a, input logic [31:0] b);
        strobe(1'b1, 1'b0, 1'b0, 1'b0);
        opClass = c;
        addMode = m;
        logicFn = f;
        srcA = a;
        srcB = b;
        @(posedge clock);
        #1;
    endtask

    // The trap output is combinational, so it is sampled before the taking edge.
    task automatic fpReport(input logic [5:0] c, input logic dv, input logic nz, input logic ri,
                            output logic trap);
        strobe(1'b0, 1'b1, 1'b0, 1'b0);
        fpCond = c;
        fpDivide = dv;
        fpDividendFinNz = nz;
        fpResvInput = ri;
        #1;
        trap = fpTrap;
        @(posedge clock);
        #1;
    endtask

    // Software is the only party that clears sticky bits, and does it with this write.
    task automatic sprWr(input logic [7:0] a, input logic [31:0] d);
        strobe(1'b0, 1'b0, 1'b1, 1'b0);
        sprAddr = a;
        sprWdata = d;
        @(posedge clock);
        #1;
    endtask

    task automatic sprRd(input logic [7:0] a, output logic [31:0] d);
        strobe(1'b0, 1'b0, 1'b0, 1'b1);
        sprAddr = a;
        @(posedge clock);
        #1;
        d = sprRdata;
    endtask
endmodule

//--- testbench/alu_status_and_fp_flags_tb.sv
`timescale 1ns/100ps
`include "afs_consts.svh"

module alu_status_and_fp_flags_tb;
    import afs_pkg::*;

    logic clock;
    logic rstn;
    logic clkEn, opValid, fpValid, fpDivide, fpDividendFinNz, fpResvInput, sprWrite, sprRead;
    afs_op_t opClass;
    afs_add_t addMode;
    afs_logic_t logicFn;
    logic [31:0] srcA, srcB, sprWdata, resultData, sprRdata;
    logic [5:0] fpCond;
    logic [7:0] sprAddr;
    logic resultValid, flagV, flagN, flagZ, flagC, divFlag, fpTrap;
    int error_cnt;
    int samples_checked;
    logic [31:0] stepM, expRes;
    logic mDf, mV, mN, mZ, mC;
    logic [5:0] mMask, mTrap, mStk;

    afs_core dut (.clock(clock), .rstn(rstn), .clkEn(clkEn), .opValid(opValid), .opClass(opClass),
        .addMode(addMode), .logicFn(logicFn), .srcA(srcA), .srcB(srcB), .resultData(resultData),
        .resultValid(resultValid), .flagV(flagV), .flagN(flagN), .flagZ(flagZ), .flagC(flagC),
        .divFlag(divFlag), .fpValid(fpValid), .fpCond(fpCond), .fpDivide(fpDivide),
        .fpDividendFinNz(fpDividendFinNz), .fpResvInput(fpResvInput), .fpTrap(fpTrap),
        .sprAddr(sprAddr), .sprWrite(sprWrite), .sprRead(sprRead), .sprWdata(sprWdata),
        .sprRdata(sprRdata));

    afs_pipe_model pipe (.clock(clock), .fpTrap(fpTrap), .sprRdata(sprRdata), .clkEn(clkEn),
        .opValid(opValid), .opClass(opClass), .addMode(addMode), .logicFn(logicFn), .srcA(srcA),
        .srcB(srcB), .fpValid(fpValid), .fpCond(fpCond), .fpDivide(fpDivide),
        .fpDividendFinNz(fpDividendFinNz), .fpResvInput(fpResvInput), .sprAddr(sprAddr),
        .sprWrite(sprWrite), .sprRead(sprRead), .sprWdata(sprWdata));

    always #10 clock = ~clock;

    // Result layout is {carry out, overflow, sum}.
    function automatic logic [33:0] addW(input logic [31:0] a, input logic [31:0] b, input logic ci);
        logic [32:0] full;
        logic [31:0] low;
        full = {1'b0, a} + {1'b0, b} + {32'h0, ci};
        low = {1'b0, a[30:0]} + {1'b0, b[30:0]} + {31'h0, ci};
        return {full[32], full[32] ^ low[31], full[31:0]};
    endfunction

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic summarize();
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic op(input afs_op_t c, input afs_add_t m, input afs_logic_t f,
                      input logic [31:0] a, input logic [31:0] b);
        logic [33:0] r;
        r = 34'h0;
        if (c == AFS_OP_LOGIC) begin
            expRes = (f == AFS_AND) ? (a & b) : (f == AFS_OR) ? (a | b) : (f == AFS_XOR) ? (a ^ b) : (a & ~b);
        end else if (c == AFS_OP_ARITH) begin
            r = addW(a, m[1] ? ~b : b, m[0] ? mC : m[1]);
            expRes = r[31:0];
        end else if (c == AFS_OP_MULST) begin
            r = addW(b, stepM[0] ? a : 32'h0, 1'b0);
            expRes = {r[31] ^ r[32], r[31:1]};
            stepM = {r[0], stepM[31:1]};
        end else begin
            r = addW({b[30:0], stepM[31]}, mDf ? ~a : a, mDf);
            expRes = r[31:0];
            stepM = {stepM[30:0], r[33]};
            mDf = r[33];
        end
        if (c != AFS_OP_LOGIC) begin
            mV = r[32];
            mC = r[33];
        end
        mN = (c == AFS_OP_LOGIC) ? expRes[31] : r[31];
        mZ = (expRes == 32'h0);
        pipe.doOp(c, m, f, a, b);
        check("resultValid", 32'h1, {31'h0, resultValid});
        check("resultData", expRes, resultData);
        check("flagVC", {30'h0, mV, mC}, {30'h0, flagV, flagC});
        check("flagNZ", {30'h0, mN, mZ}, {30'h0, flagN, flagZ});
        check("divFlag", {31'h0, mDf}, {31'h0, divFlag});
    endtask

    task automatic checkSpr();
        logic [31:0] d;
        pipe.sprRd(`AFS_SPR_STEP, d);
        check("stepOperand", stepM, d);
        pipe.sprRd(`AFS_SPR_ALU, d);
        check("aluStatus", {20'h0, mDf, mV, mN, mZ, mC, 7'h0}, d);
        pipe.sprRd(`AFS_SPR_ENV, d);
        check("envMask", {26'h0, mMask}, d);
        pipe.sprRd(`AFS_SPR_FST, d);
        check("fpStatus", {18'h0, mTrap, 2'h0, mStk}, d);
    endtask

    task automatic fpRun(input logic [5:0] c, input logic dv, input logic nz, input logic ri);
        logic [5:0] q;
        logic t;
        q = c;
        q[1] = c[1] | ri;
        q[5] = c[5] & dv & nz;
        pipe.fpReport(c, dv, nz, ri, t);
        check("fpTrap", {31'h0, |(q & ~mMask)}, {31'h0, t});
        mStk = mStk | (q & mMask);
        if (|(q & ~mMask)) begin
            mTrap = {q[5], c[4:0]};
        end
    endtask

    initial begin
        int k;
        logic [31:0] d;
        clock = 1'b0;
        rstn = 1'b0;
        error_cnt = 0;
        samples_checked = 0;
        {stepM, expRes, mV, mN, mZ, mC, mMask, mTrap, mStk} = '0;
        mDf = 1'b1;
        void'($urandom(79359));
        repeat (4) @(posedge clock);
        #1;
        rstn = 1'b1;
        checkSpr();
        op(AFS_OP_ARITH, AFS_ADD, AFS_AND, 32'h7fffffff, 32'h1);
        op(AFS_OP_ARITH, AFS_SUB, AFS_AND, 32'h5, 32'h5);
        op(AFS_OP_ARITH, AFS_ADD, AFS_AND, 32'hffffffff, 32'h1);
        op(AFS_OP_LOGIC, AFS_ADD, AFS_XOR, 32'h80000000, 32'h0);
        op(AFS_OP_ARITH, AFS_ADDC, AFS_AND, 32'h0, 32'h0);
        op(AFS_OP_ARITH, AFS_SUBC, AFS_AND, 32'h0, 32'h0);
        fpRun(6'h23, 1'b1, 1'b1, 1'b1);
        fpRun(6'h20, 1'b1, 1'b0, 1'b0);
        for (int i = 0; i < 400; i++) begin
            k = $urandom_range(0, 11);
            d = $urandom();
            if (k == 0) begin
                pipe.sprWr(`AFS_SPR_STEP, d);
                stepM = d;
            end else if (k == 1) begin
                pipe.sprWr(`AFS_SPR_ALU, d);
                {mDf, mV, mN, mZ, mC} = d[11:7];
            end else if (k == 2) begin
                pipe.sprWr(`AFS_SPR_ENV, d);
                mMask = d[5:0];
            end else if (k == 3) begin
                pipe.sprWr(`AFS_SPR_FST, d);
                mTrap = d[13:8];
                mStk = d[5:0];
            end else if (k < 9) begin
                op(afs_op_t'(4'h1 << $urandom_range(0, 3)), afs_add_t'(2'($urandom())),
                   afs_logic_t'(2'($urandom())), $urandom(), d);
            end else begin
                fpRun(6'($urandom()), 1'($urandom()), 1'($urandom()), 1'($urandom()));
            end
            if (i % 8 == 0) begin
                checkSpr();
            end
        end
        pipe.sprWr(8'h55, 32'hffffffff);
        pipe.sprRd(8'h55, d);
        check("unmappedRead", 32'h0, d);
        checkSpr();
        pipe.setEnable(1'b0);
        pipe.doOp(AFS_OP_ARITH, AFS_ADD, AFS_AND, 32'h1, ~expRes);
        check("frozenValid", 32'h0, {31'h0, resultValid});
        check("frozenData", expRes, resultData);
        pipe.setEnable(1'b1);
        summarize();
    end

    // Far more than the roughly 630 cycles the sequence needs.
    initial begin
        #400000;
        error_cnt++;
        summarize();
    end
endmodule
